// ===== rtl/gdfp_pkg.sv
// Constants, encodings and carrier types for the gate driver fault protection
package gdfp_pkg;
   localparam int unsigned CLK_HZ       = 40_000_000;
   localparam int unsigned NUM_PHASE    = 3;
   localparam int unsigned MA_W         = 12;
   // Protective turn-off fixed sink period
   localparam int unsigned TURNOFF_US   = 40;
   localparam int unsigned TURNOFF_CYC  = TURNOFF_US * (CLK_HZ / 1_000_000);
   // Auto-recovery wait of the pin-strapped version
   localparam int unsigned RETRY_MS     = 4;
   localparam int unsigned RETRY_CYC    = RETRY_MS * (CLK_HZ / 1_000);
   // Plain defaults where no figure is given
   localparam int unsigned OC_FILTER_CYC_DEF   = 40;
   localparam int unsigned GATE_SETTLE_CYC_DEF = 80;
   localparam int unsigned ENA_RESET_CYC_DEF   = 800;
   // Reset values
   localparam logic        ALARM_N_RST     = 1'h1;
   localparam logic        GENTLE_OFF_RST  = 1'h0;
   localparam logic        PUMP_RUN_RST    = 1'h1;
   // Overcurrent response selector
   localparam logic [1:0]  OC_LATCH  = 2'h0;
   localparam logic [1:0]  OC_AUTO   = 2'h1;
   localparam logic [1:0]  OC_REPORT = 2'h2;
   localparam logic [1:0]  OC_OFF    = 2'h3;

   typedef enum logic [1:0] {UV_RUN, UV_SINK, UV_FLOAT} gdfp_uv_state_type;

   // One bit per transistor; packs to {hi[2:0], lo[2:0]}
   typedef struct packed {
      logic [NUM_PHASE-1:0] hi;
      logic [NUM_PHASE-1:0] lo;
   } gdfp_gates_type;

   typedef struct packed {
      logic [1:0] oc_mode;
      logic       cycle_recover_en;
      logic       oc_shutoff_scope;
      logic       shunt_shutoff_scope;
      logic       shunt_detect_off;
      logic       drain_detect_off;
   } gdfp_oc_cfg_type;
endpackage : gdfp_pkg

// ===== rtl/gdfp_persist.sv
// Persistence filter: hit once the level has stood longer than LIMIT cycles
`timescale 1ns/1ps
module gdfp_persist #(
   parameter int unsigned LIMIT = 40
) (
   input  wire logic clk_sys_i,
   input  wire logic rstn_i,
   input  wire logic clr_i,
   input  wire logic level_i,
   output logic      hit_o
);
   localparam int unsigned CW = $clog2(LIMIT + 2);

   logic [CW-1:0] cnt_ff;
   logic [CW-1:0] nxt_cnt;

   always_comb
   begin
      nxt_cnt = cnt_ff;
      if (clr_i || !level_i)
         nxt_cnt = '0;
      else if (cnt_ff <= CW'(LIMIT))
         nxt_cnt = cnt_ff + CW'(1);
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
         cnt_ff <= '0;
      else
         cnt_ff <= nxt_cnt;
   end

   // Any dropout restarts the count, so glitches never qualify
   assign hit_o = (cnt_ff > CW'(LIMIT));
endmodule : gdfp_persist

// ===== rtl/gdfp_soft_sink.sv
// Soft-shutdown sink current table, registered output
`timescale 1ns/1ps
module gdfp_soft_sink #(
   parameter int unsigned MA_W = 12
) (
   input  wire logic            clk_sys_i,
   input  wire logic            rstn_i,
   input  wire logic [MA_W-1:0] drive_ma_i,
   output logic      [MA_W-1:0] soft_ma_o
);
   logic [MA_W-1:0] soft_ff;
   logic [MA_W-1:0] nxt_soft;

   always_comb
   begin
      case (drive_ma_i)
         12'h7D0: nxt_soft = 12'h370; // 2000 -> 880
         12'h668: nxt_soft = 12'h2E4; // 1640 -> 740
         12'h550: nxt_soft = 12'h294; // 1360 -> 660
         12'h474: nxt_soft = 12'h208; // 1140 -> 520
         12'h370: nxt_soft = 12'h17C; // 880 -> 380
         12'h2E4: nxt_soft = 12'h154; // 740 -> 340
         12'h294: nxt_soft = 12'h118; // 660 -> 280
         12'h208: nxt_soft = 12'h0F0; // 520 -> 240
         12'h17C: nxt_soft = 12'h0A0; // 380 -> 160
         12'h154: nxt_soft = 12'h078; // 340 -> 120
         12'h118: nxt_soft = 12'h03C; // 280 -> 60
         // 240 and below, and unlisted codes, use the weakest sink
         default: nxt_soft = 12'h014;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
         soft_ff <= 12'h014;
      else
         soft_ff <= nxt_soft;
   end

   assign soft_ma_o = soft_ff;
endmodule : gdfp_soft_sink

// ===== rtl/gdfp_top.sv
// Fault protection for a three-phase half-bridge gate driver
`timescale 1ns/1ps
module gdfp_top #(
   parameter int unsigned RETRY_CYC       = gdfp_pkg::RETRY_CYC,
   parameter int unsigned OC_FILTER_CYC   = gdfp_pkg::OC_FILTER_CYC_DEF,
   parameter int unsigned GATE_SETTLE_CYC = gdfp_pkg::GATE_SETTLE_CYC_DEF,
   parameter int unsigned ENA_RESET_CYC   = gdfp_pkg::ENA_RESET_CYC_DEF
) (
   input  wire logic                      clk_sys_i,
   input  wire logic                      rstn_i,
   input  wire logic                      logic_supply_low_i,
   input  wire logic                      motor_supply_low_i,
   input  wire logic                      drain_sense_supply_low_i,
   input  wire logic                      pump_rail_low_i,
   input  wire logic                      pin_strap_i,
   input  wire gdfp_pkg::gdfp_oc_cfg_type oc_cfg_i,
   input  wire logic                      gentle_off_wr_i,
   input  wire logic                      gentle_off_disable_i,
   input  wire logic                      turnoff_timing_sel_i,
   input  wire logic                      gate_monitor_off_i,
   input  wire logic [11:0]               sink_strength_set_i,
   input  wire gdfp_pkg::gdfp_gates_type  gate_cmd_i,
   input  wire gdfp_pkg::gdfp_gates_type  gate_reached_i,
   input  wire gdfp_pkg::gdfp_gates_type  gate_below_low_i,
   input  wire gdfp_pkg::gdfp_gates_type  drain_over_i,
   input  wire logic [2:0]                shunt_over_i,
   input  wire logic                      enable_i,
   input  wire logic                      alarm_clear_cmd_i,
   output gdfp_pkg::gdfp_gates_type       gate_drive_o,
   output gdfp_pkg::gdfp_gates_type       gate_oe_o,
   output logic [11:0]                    sink_ma_o,
   output logic                           pump_run_o,
   output logic                           alarm_n_out_o,
   output logic                           summary_flag_o,
   output logic                           supply_low_flag_o,
   output logic                           pump_low_flag_o,
   output logic                           oc_flag_o,
   output gdfp_pkg::gdfp_gates_type       drain_oc_flag_o,
   output logic [2:0]                     shunt_over_flag_o,
   output logic                           gate_level_fault_flag_o,
   output gdfp_pkg::gdfp_gates_type       gate_level_flag_o
);
   localparam int unsigned NB  = 2 * gdfp_pkg::NUM_PHASE;
   localparam int unsigned ENW = $clog2(ENA_RESET_CYC + 1);
   localparam int unsigned TW  = $clog2(gdfp_pkg::TURNOFF_CYC + 1);
   localparam int unsigned RW  = $clog2(RETRY_CYC + 1);

   logic [NB-1:0] cmd6, reach6, below6, dover6;
   logic          halt, uv_pwr, uv_any, clr, strap;
   assign cmd6   = gate_cmd_i;
   assign reach6 = gate_reached_i;
   assign below6 = gate_below_low_i;
   assign dover6 = drain_over_i;
   assign strap  = pin_strap_i;
   assign halt   = logic_supply_low_i;
   assign uv_pwr = motor_supply_low_i | drain_sense_supply_low_i;
   assign uv_any = uv_pwr | pump_rail_low_i;

   // Error-reset pulse on a short enable low
   logic           ena_prev_ff, nxt_ena_prev, clr_pulse_ff, nxt_clr_pulse;
   logic [ENW-1:0] ena_low_ff, nxt_ena_low;

   always_comb
   begin
      nxt_ena_prev  = enable_i;
      nxt_clr_pulse = 1'h0;
      nxt_ena_low   = ena_low_ff;
      if (!enable_i)
      begin
         if (ena_low_ff < ENW'(ENA_RESET_CYC))
            nxt_ena_low = ena_low_ff + ENW'(1);
      end
      else
      begin
         nxt_ena_low = '0;
         if (!ena_prev_ff && ena_low_ff < ENW'(ENA_RESET_CYC))
            nxt_clr_pulse = 1'h1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ena_prev_ff  <= 1'h1;
         clr_pulse_ff <= 1'h0;
         ena_low_ff   <= '0;
      end
      else
      begin
         ena_prev_ff  <= nxt_ena_prev;
         clr_pulse_ff <= nxt_clr_pulse;
         ena_low_ff   <= nxt_ena_low;
      end
   end

   assign clr = alarm_clear_cmd_i | clr_pulse_ff;

   // Undervolt turn-off sequence and gentle-off setting
   gdfp_pkg::gdfp_uv_state_type uv_st_ff, nxt_uv_st;
   logic [TW-1:0] sink_cnt_ff, nxt_sink_cnt;
   logic          gentle_ff, nxt_gentle, sink_done;

   always_comb
   begin
      nxt_uv_st    = uv_st_ff;
      nxt_sink_cnt = '0;
      nxt_gentle   = gentle_off_wr_i ? gentle_off_disable_i : gentle_ff;
      sink_done    = turnoff_timing_sel_i ?
                     (sink_cnt_ff >= TW'(gdfp_pkg::TURNOFF_CYC - 1)) : (&below6);
      case (uv_st_ff)
         gdfp_pkg::UV_RUN:
            if (uv_any)
               nxt_uv_st = gdfp_pkg::UV_SINK;
         gdfp_pkg::UV_SINK:
            if (!uv_any)
               nxt_uv_st = gdfp_pkg::UV_RUN;
            else if (sink_done)
               nxt_uv_st = gdfp_pkg::UV_FLOAT;
            else
               nxt_sink_cnt = sink_cnt_ff + TW'(1);
         gdfp_pkg::UV_FLOAT:
            if (!uv_any)
               nxt_uv_st = gdfp_pkg::UV_RUN;
         default:
            nxt_uv_st = gdfp_pkg::UV_RUN;
      endcase
      if (halt)
      begin
         nxt_uv_st  = gdfp_pkg::UV_RUN;
         nxt_gentle = gdfp_pkg::GENTLE_OFF_RST;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         uv_st_ff    <= gdfp_pkg::UV_RUN;
         sink_cnt_ff <= '0;
         gentle_ff   <= gdfp_pkg::GENTLE_OFF_RST;
      end
      else
      begin
         uv_st_ff    <= nxt_uv_st;
         sink_cnt_ff <= nxt_sink_cnt;
         gentle_ff   <= nxt_gentle;
      end
   end

   // Overcurrent and gate-level detectors
   logic [NB-1:0] dhit6, ghit6, gate_oe_ff;
   logic [2:0]    shit3;
   logic          monitor_en;
   assign monitor_en = strap | !gate_monitor_off_i;

   for (genvar g = 0; g < NB; g++)
   begin : g_gate
      gdfp_persist #(.LIMIT(OC_FILTER_CYC)) u_drain (
         .clk_sys_i (clk_sys_i),
         .rstn_i    (rstn_i),
         .clr_i     (halt),
         .level_i   (dover6[g]),
         .hit_o     (dhit6[g])
      );
      gdfp_persist #(.LIMIT(GATE_SETTLE_CYC)) u_settle (
         .clk_sys_i (clk_sys_i),
         .rstn_i    (rstn_i),
         .clr_i     (halt),
         .level_i   (gate_oe_ff[g] & ~reach6[g] & monitor_en),
         .hit_o     (ghit6[g])
      );
   end
   for (genvar s = 0; s < 3; s++)
   begin : g_shunt
      gdfp_persist #(.LIMIT(OC_FILTER_CYC)) u_shunt (
         .clk_sys_i (clk_sys_i),
         .rstn_i    (rstn_i),
         .clr_i     (halt),
         .level_i   (shunt_over_i[s]),
         .hit_o     (shit3[s])
      );
   end

   // Overcurrent flags and retry
   logic [1:0]    mode;
   logic          drain_en, shunt_en, retry_done, oc_cut, oc_any;
   logic [NB-1:0] dflag_ff, nxt_dflag, cmd_prev_ff;
   logic [2:0]    sflag_ff, nxt_sflag, dph, phase_off;
   logic [RW-1:0] rcnt_ff, nxt_rcnt;

   assign mode     = strap ? gdfp_pkg::OC_AUTO : oc_cfg_i.oc_mode;
   assign drain_en = (mode != gdfp_pkg::OC_OFF) &&
                     !(strap && oc_cfg_i.drain_detect_off);
   assign shunt_en = (mode != gdfp_pkg::OC_OFF) &&
                     (strap || !oc_cfg_i.shunt_detect_off);
   assign oc_any   = (|dflag_ff) | (|sflag_ff);

   always_comb
   begin
      nxt_dflag  = dflag_ff;
      nxt_sflag  = sflag_ff;
      nxt_rcnt   = '0;
      retry_done = 1'h0;
      if (mode == gdfp_pkg::OC_AUTO && oc_any)
      begin
         if (rcnt_ff >= RW'(RETRY_CYC - 1) ||
             (oc_cfg_i.cycle_recover_en && !strap && cmd6 != cmd_prev_ff))
            retry_done = 1'h1;
         else
            nxt_rcnt = rcnt_ff + RW'(1);
      end
      for (int i = 0; i < NB; i++)
      begin
         if ((clr && !dover6[i]) || retry_done)
            nxt_dflag[i] = 1'h0;
         if (dhit6[i] && drain_en)
            nxt_dflag[i] = 1'h1;
      end
      for (int p = 0; p < 3; p++)
      begin
         if ((clr && !shunt_over_i[p]) || retry_done)
            nxt_sflag[p] = 1'h0;
         if (shit3[p] && shunt_en)
            nxt_sflag[p] = 1'h1;
      end
      if (halt)
      begin
         nxt_dflag = '0;
         nxt_sflag = '0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         dflag_ff    <= '0;
         sflag_ff    <= '0;
         rcnt_ff     <= '0;
         cmd_prev_ff <= '0;
      end
      else
      begin
         dflag_ff    <= nxt_dflag;
         sflag_ff    <= nxt_sflag;
         rcnt_ff     <= nxt_rcnt;
         cmd_prev_ff <= cmd6;
      end
   end

   // Report mode never cuts drive
   assign oc_cut    = (mode == gdfp_pkg::OC_LATCH) || (mode == gdfp_pkg::OC_AUTO);
   assign dph       = dflag_ff[2:0] | dflag_ff[5:3];
   assign phase_off = !oc_cut ? 3'h0 :
      (((strap || oc_cfg_i.oc_shutoff_scope) && |dph) ? 3'h7 : dph) |
      (((strap || oc_cfg_i.shunt_shutoff_scope || oc_cfg_i.oc_shutoff_scope)
        && |sflag_ff) ? 3'h7 : sflag_ff);

   // Gate-level, supply and pump flags
   logic [NB-1:0] gflag_ff, nxt_gflag;
   logic          sup_ff, nxt_sup, pflag_ff, nxt_pflag, gdf_any;
   assign gdf_any = |gflag_ff;

   always_comb
   begin
      nxt_gflag = gflag_ff;
      for (int i = 0; i < NB; i++)
      begin
         if (clr && !ghit6[i])
            nxt_gflag[i] = 1'h0;
         if (ghit6[i])
            nxt_gflag[i] = 1'h1;
      end
      nxt_sup   = (sup_ff & ~clr) | uv_pwr;
      nxt_pflag = (pflag_ff & ~clr) | pump_rail_low_i;
      if (halt)
      begin
         nxt_gflag = '0;
         nxt_sup   = 1'h0;
         nxt_pflag = 1'h0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         gflag_ff <= '0;
         sup_ff   <= 1'h0;
         pflag_ff <= 1'h0;
      end
      else
      begin
         gflag_ff <= nxt_gflag;
         sup_ff   <= nxt_sup;
         pflag_ff <= nxt_pflag;
      end
   end

   // Gate outputs, sink current, pump and alarm
   logic [NB-1:0]   drv_ff, nxt_drv, nxt_oe;
   logic [11:0]     soft_ma, sink_ff, nxt_sink;
   logic            pump_ff, nxt_pump, alarm_ff, nxt_alarm, sum_ff, nxt_sum;
   logic            oc_ff, nxt_oc, gdf_ff, nxt_gdf, protect;

   gdfp_soft_sink #(.MA_W(gdfp_pkg::MA_W)) u_soft (
      .clk_sys_i  (clk_sys_i),
      .rstn_i     (rstn_i),
      .drive_ma_i (sink_strength_set_i),
      .soft_ma_o  (soft_ma)
   );

   assign protect = (uv_st_ff != gdfp_pkg::UV_RUN) || uv_any || (|phase_off);

   always_comb
   begin
      for (int i = 0; i < NB; i++)
      begin
         nxt_oe[i]  = 1'h1;
         nxt_drv[i] = cmd6[i];
         if (halt || gdf_any || uv_st_ff == gdfp_pkg::UV_FLOAT)
         begin
            nxt_oe[i]  = 1'h0;
            nxt_drv[i] = 1'h0;
         end
         else if (uv_any || uv_st_ff == gdfp_pkg::UV_SINK || phase_off[i % 3])
            nxt_drv[i] = 1'h0;
      end
      // Soft sink unless the gentle-off disable is set
      nxt_sink  = (protect && !gentle_ff) ? soft_ma : sink_strength_set_i;
      nxt_pump  = !halt && !(uv_pwr && uv_st_ff == gdfp_pkg::UV_FLOAT);
      nxt_oc    = (|nxt_dflag) | (|nxt_sflag);
      nxt_gdf   = |nxt_gflag;
      nxt_sum   = nxt_oc | nxt_sup | nxt_pflag | (|nxt_gflag);
      nxt_alarm = !(halt || uv_any || nxt_oc || (|nxt_gflag));
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         drv_ff     <= '0;
         gate_oe_ff <= '0;
         sink_ff    <= '0;
         pump_ff    <= gdfp_pkg::PUMP_RUN_RST;
         alarm_ff   <= gdfp_pkg::ALARM_N_RST;
         sum_ff     <= 1'h0;
         oc_ff      <= 1'h0;
         gdf_ff     <= 1'h0;
      end
      else
      begin
         drv_ff     <= nxt_drv;
         gate_oe_ff <= nxt_oe;
         sink_ff    <= nxt_sink;
         pump_ff    <= nxt_pump;
         alarm_ff   <= nxt_alarm;
         sum_ff     <= nxt_sum;
         oc_ff      <= nxt_oc;
         gdf_ff     <= nxt_gdf;
      end
   end

   assign gate_drive_o            = drv_ff;
   assign gate_oe_o               = gate_oe_ff;
   assign sink_ma_o               = sink_ff;
   assign pump_run_o              = pump_ff;
   assign alarm_n_out_o           = alarm_ff;
   assign summary_flag_o          = sum_ff;
   assign supply_low_flag_o       = sup_ff;
   assign pump_low_flag_o         = pflag_ff;
   assign oc_flag_o               = oc_ff;
   assign drain_oc_flag_o         = dflag_ff;
   assign shunt_over_flag_o       = sflag_ff;
   assign gate_level_fault_flag_o = gdf_ff;
   assign gate_level_flag_o       = gflag_ff;

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);

   a_halt_floats: assert property (halt |=> (gate_oe_o == '0 && !supply_low_flag_o))
      else $error("logic supply low did not float gates");
   a_uv_alarm: assert property ((uv_pwr && !halt) |=> (!alarm_n_out_o && supply_low_flag_o))
      else $error("supply undervolt without alarm and flag");
   a_sup_sticky: assert property ((sup_ff && !clr && !halt) |=> supply_low_flag_o)
      else $error("supply low flag lost without clear");
   a_pump_flag: assert property ((pump_rail_low_i && !halt) |=> (pump_low_flag_o && !alarm_n_out_o))
      else $error("pump low not flagged");
   a_uv_float: assert property ((uv_st_ff == gdfp_pkg::UV_FLOAT && uv_pwr && !halt)
      |=> (gate_oe_o == '0 && !pump_run_o))
      else $error("gates not floated or pump running");
   a_fixed_sink: assert property ((uv_st_ff == gdfp_pkg::UV_SINK && turnoff_timing_sel_i && uv_any
      && !halt && sink_cnt_ff == TW'(gdfp_pkg::TURNOFF_CYC - 1))
      |=> uv_st_ff == gdfp_pkg::UV_FLOAT)
      else $error("fixed sink period wrong");
   a_soft_sink: assert property ((protect && !gentle_ff) |=> (sink_ma_o == $past(soft_ma)))
      else $error("soft sink not applied");
   // The hit lags the comparator by one edge, so look two and three edges back
   a_oc_filter: assert property ($rose(dflag_ff[0])
      |-> ($past(dover6[0], 2) && $past(dover6[0], 3)))
      else $error("drain overcurrent flagged without persistence");
   a_latch_hold: assert property ((mode == gdfp_pkg::OC_LATCH && dflag_ff[0] && !clr && !halt)
      |=> drain_oc_flag_o[0])
      else $error("latched overcurrent released without clear");
   a_report_drive: assert property ((mode == gdfp_pkg::OC_REPORT && uv_st_ff == gdfp_pkg::UV_RUN
      && !uv_any && !gdf_any && !halt) |=> (gate_drive_o == $past(cmd6)))
      else $error("report mode cut the drive");
   a_strap_all_off: assert property ((strap && |dflag_ff && !halt && !uv_any && !gdf_any)
      |=> gate_drive_o == '0)
      else $error("strapped overcurrent left a bridge on");
   a_gdf_float: assert property ((gdf_any && !clr && !halt)
      |=> (gate_oe_o == '0 && !alarm_n_out_o))
      else $error("gate fault did not float gates");
endmodule : gdfp_top

// ===== tb/gdfp_bridge_model.sv
// Half-bridge model: gates follow the driver while it drives them
`timescale 1ns/1ps
module gdfp_bridge_model (
   input  wire logic                     clk_sys_i,
   input  wire logic                     slow_i,
   input  wire gdfp_pkg::gdfp_gates_type drive_i,
   input  wire gdfp_pkg::gdfp_gates_type oe_i,
   output gdfp_pkg::gdfp_gates_type      reached_o,
   output gdfp_pkg::gdfp_gates_type      below_low_o
);
   // Floated gates sink through the pull-downs, so they read low
   always_ff @(posedge clk_sys_i)
   begin
      reached_o   <= slow_i ? '0 : oe_i;
      below_low_o <= ~(drive_i & oe_i);
   end
endmodule : gdfp_bridge_model

// ===== tb/gdfp_top_tb.sv
// Self-checking bench for the gate driver fault protection
`timescale 1ns/1ps
module gdfp_top_tb;
   logic clk_sys_i = 0, rstn_i = 0, mot = 0, drn = 0, cpu = 0, slow = 0, en = 1, clr = 0;
   logic hlt = 0, strp = 0, gwr = 0, gdis = 0, tsel = 1, gmo = 0;
   logic [31:0] seed = 32'h4f5e_7200;
   logic [11:0] snk = 12'h07d0, sink;
   logic [2:0]  sov = 3'h0, sof;
   logic        pump, alm_n, summ, uvf, cpf, ocf, gate_level_fault_flag;
   int          failures = 0, samples_checked = 0, cyc = 0;
   logic [11:0] tbl[3] = '{12'h07d0, 12'h0668, 12'h00c8};
   gdfp_pkg::gdfp_oc_cfg_type cfg = 7'h08;
   gdfp_pkg::gdfp_gates_type  cmd = '0, prv = '0, dov = '0, drv, oe, rch, blw, dvf, vgf;

   gdfp_top #(.RETRY_CYC(50), .OC_FILTER_CYC(4), .GATE_SETTLE_CYC(8), .ENA_RESET_CYC(16))
   i_gdfp_top (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .logic_supply_low_i(hlt),
      .motor_supply_low_i(mot), .drain_sense_supply_low_i(drn), .pump_rail_low_i(cpu),
      .pin_strap_i(strp), .oc_cfg_i(cfg), .gentle_off_wr_i(gwr),
      .gentle_off_disable_i(gdis), .turnoff_timing_sel_i(tsel), .gate_monitor_off_i(gmo),
      .sink_strength_set_i(snk), .gate_cmd_i(cmd), .gate_reached_i(rch),
      .gate_below_low_i(blw), .drain_over_i(dov), .shunt_over_i(sov), .enable_i(en),
      .alarm_clear_cmd_i(clr), .gate_drive_o(drv), .gate_oe_o(oe), .sink_ma_o(sink),
      .pump_run_o(pump), .alarm_n_out_o(alm_n), .summary_flag_o(summ),
      .supply_low_flag_o(uvf), .pump_low_flag_o(cpf), .oc_flag_o(ocf),
      .drain_oc_flag_o(dvf), .shunt_over_flag_o(sof), .gate_level_fault_flag_o(gate_level_fault_flag),
      .gate_level_flag_o(vgf));
   gdfp_bridge_model i_gdfp_bridge_model (.clk_sys_i(clk_sys_i), .slow_i(slow),
      .drive_i(drv), .oe_i(oe), .reached_o(rch), .below_low_o(blw));

   always #12.5 clk_sys_i = ~clk_sys_i;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // Unlisted strengths fall to the floor value
   function automatic logic [11:0] exp_soft(input logic [11:0] d);
      return d == 12'h07d0 ? 12'h0370 : d == 12'h0668 ? 12'h02e4 : 12'h0014;
   endfunction : exp_soft

   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      samples_checked++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic stop_test();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test

   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : wt

   // Short enable low or one-cycle clear command
   task automatic clear(input logic by_en);
      en  <= ~by_en;
      clr <= ~by_en;
      @(posedge clk_sys_i);
      clr <= 1'h0;
      wt(2);
      en <= 1'h1;
      wt(3);
   endtask : clear

   always @(posedge clk_sys_i)
   begin
      seed <= lfsr(seed);
      cmd  <= seed[5:0];
      prv  <= cmd;
      cyc++;
      if (cyc == 20000)
      begin
         failures++;
         stop_test();
      end
   end

   initial
   begin
      wt(16);
      rstn_i <= 1'h1;
      for (int i = 0; i < 3; i++)
      begin
         snk  <= tbl[i];
         gwr  <= (i != 0);
         gdis <= (i == 1);
         tsel <= (i != 2);
         wt(2);
         gwr  <= 1'h0;
         if (i == 0) mot <= 1'h1; else if (i == 1) drn <= 1'h1; else cpu <= 1'h1;
         wt(4);
         chk("alarm", 12'h0, alm_n);
         chk("flag", 12'h1, i == 2 ? cpf : uvf);
         chk("sink", i == 1 ? tbl[i] : exp_soft(tbl[i]), sink);
         chk("sink_oe", i == 2 ? 12'h0 : 12'h3f, oe);
         wt(1600);
         chk("oe", 12'h0, oe);
         if (i < 2) chk("pump", 12'h0, pump);
         {mot, drn, cpu} <= 3'h0;
         wt(3);
         chk("released", 12'h1, alm_n);
         chk("sticky", 12'h1, i == 2 ? cpf : uvf);
         clear(i[0]);
         chk("cleared", 12'h0, {cpf, uvf});
      end
      dov <= 6'h01;
      wt(4);
      dov <= 6'h00;
      wt(6);
      chk("short", 12'h0, ocf);
      for (int m = 0; m < 4; m++)
      begin
         cfg.oc_mode <= m[1:0];
         dov <= 6'h01;
         sov <= 3'h2;
         wt(10);
         chk("alarm", {11'h0, m == 3}, alm_n);
         chk("drain", m == 3 ? 12'h0 : 12'h1, dvf);
         chk("shunt", m == 3 ? 12'h0 : 12'h2, sof);
         chk("gates", m[1] ? prv : 12'h0, drv);
         {dov, sov} <= '0;
         // Filter hit lingers one edge after the comparator drops
         wt(1);
         if (m == 1) wt(60); else clear(m[0]);
         chk("oc", 12'h0, {summ, ocf});
      end
      // Offending bridge only, shunt detect off, retry on input change
      cfg <= 7'h32;
      dov <= 6'h01;
      sov <= 3'h4;
      wt(10);
      chk("scope", {6'h0, prv & 6'h36}, drv);
      chk("shunt_off", 12'h0, sof);
      {dov, sov} <= '0;
      wt(5);
      chk("cycle", 12'h0, ocf);
      // Monitor off, on, and strapped with the off bit set
      for (int k = 0; k < 3; k++)
      begin
         {slow, gmo, strp} <= {1'h1, k != 1, k == 2};
         wt(14);
         chk("gdf", {11'h0, k != 0}, gate_level_fault_flag);
         chk("float", k == 0 ? 12'h3f : 12'h0, oe);
         slow <= 1'h0;
         clear(1'h0);
         chk("gdf", 12'h0, gate_level_fault_flag);
      end
      // Strapped: report selector overridden, all bridges off, timed retry
      cfg <= 7'h40;
      dov <= 6'h08;
      wt(10);
      chk("strap", 12'h0, drv);
      dov <= 6'h00;
      wt(60);
      chk("retry", 12'h0, {summ, ocf});
      cfg.drain_detect_off <= 1'h1;
      dov <= 6'h08;
      wt(10);
      chk("drain_off", 12'h0, dvf);
      // Logic supply low in mid-fault, gentle-off set beforehand
      dov <= 6'h00;
      {mot, gwr, gdis} <= 3'h7;
      wt(2);
      gwr <= 1'h0;
      {hlt, mot} <= 2'h2;
      wt(2);
      chk("halt", 12'h0, {oe, pump, alm_n, uvf});
      {hlt, mot} <= 2'h1;
      wt(3);
      chk("gentle", exp_soft(snk), sink);
      mot <= 1'h0;
      wt(3);
      chk("resume", 12'h07f, {alm_n, oe});
      stop_test();
   end
endmodule : gdfp_top_tb
